// [hdl/ffs_pkg.sv]
/*
 * ffs_pkg: shared constants and types of the flyback fault and startup
 * sequencer: timing figures and derived cycle counts, register offsets,
 * event bit positions, sequencer states and the comparator input bundle.
 * Assumes a single 100 MHz core clock.
 */
package ffs_pkg;

    // core clock
    localparam int CLK_PERIOD_NS = 10;

    // timing figures in their own units
    localparam int LINE_SAMPLE_WINDOW_NS = 100_000;      // 100 us
    localparam int SUPPLY_OV_DEBOUNCE_TIME_NS = 70_000;  // 70 us
    localparam int BROWNOUT_TIME_NS = 16_500_000;        // 16.5 ms
    localparam int MIN_BOUNDARY_FREQUENCY_HZ = 20_000;   // 20 kHz
    localparam int MIN_BOUNDARY_PERIOD_NS =
        1_000_000_000 / MIN_BOUNDARY_FREQUENCY_HZ;

    // counter widths
    localparam int CNT_W = 24;
    localparam int CYC_W = 4;

    // derived cycle counts: windows round down, least times round up
    localparam logic [CNT_W-1:0] LINE_SAMPLE_WINDOW_CYC =
        CNT_W'(LINE_SAMPLE_WINDOW_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SUPPLY_OV_DEBOUNCE_CYC =
        CNT_W'((SUPPLY_OV_DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1)
               / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] BROWNOUT_CYC =
        CNT_W'((BROWNOUT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] MIN_BOUNDARY_PERIOD_CYC =
        CNT_W'((MIN_BOUNDARY_PERIOD_NS + CLK_PERIOD_NS - 1)
               / CLK_PERIOD_NS);

    // switching cycle limits
    localparam logic [CYC_W-1:0] SENSE_OV_CYCLE_COUNT = 4'h2;
    localparam logic [CYC_W-1:0] SENSE_UV_CYCLE_COUNT = 4'h2;

    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_EVENT_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_EVENT_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SEQ_STATE = 8'h08;
    localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h0C;

    // event bit positions
    localparam int EV_W = 8;
    localparam int EV_BROWN_IN_FAIL = 0;
    localparam int EV_SUPPLY_OV = 1;
    localparam int EV_BROWNOUT = 2;
    localparam int EV_OVER_TEMP = 3;
    localparam int EV_SENSE_OV = 4;
    localparam int EV_SENSE_UV = 5;
    localparam int EV_FREQ_FLOOR = 6;
    localparam int EV_LATCH_RELEASE = 7;

    // control register field
    localparam int CTRL_SOFT_STOP = 0;

    // sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_CHARGE = 5'h01,  // startup source on, waiting for turn-on level
        ST_SAMPLE = 5'h02,  // line sampling window
        ST_RUN = 5'h04,     // switching
        ST_STOP = 5'h08,    // protection: gate off, supply falling
        ST_LOWPWR = 5'h10   // reduced current, waiting re-enable level
    } ffs_state_t;

    // analog comparator flags, all asynchronous to the core clock
    typedef struct packed {
        logic supply_on;          // supply at or above turn-on level
        logic supply_off;         // supply below turn-off level
        logic startup_reenable;   // supply at startup_reenable_level
        logic latch_release;      // supply at latch_release_level
        logic brown_in_ok;        // sampled bulk voltage above reference
        logic supply_ov;          // supply_overvoltage_fault comparator
        logic line_low;           // line_sense_current below limit
        logic over_temp;          // junction over temperature
        logic sense_ov;           // sense_overvoltage_fault sample
        logic sense_uv;           // sense_undervoltage_fault sample
        logic zcd;                // secondary_zero_current_detect
        logic osc_done;           // minimum oscillator period elapsed
        logic gate_off_req;       // pulse width comparator ends on-time
    } ffs_cmp_t;

    // whole state of the sequencer
    typedef struct packed {
        ffs_cmp_t sync1;
        ffs_cmp_t sync2;
        ffs_state_t st;
        logic latched;
        logic gate;
        logic zcd_seen;
        logic floor_hit;
        logic [CNT_W-1:0] tmr;
        logic [CNT_W-1:0] ovp_cnt;
        logic [CNT_W-1:0] bo_cnt;
        logic [CYC_W-1:0] sov_cnt;
        logic [CYC_W-1:0] suv_cnt;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic soft_stop;
        logic [DATA_W-1:0] rdata;
    } ffs_regs_t;

endpackage : ffs_pkg

// [hdl/ffs_sequencer.sv]
/*
 * ffs_sequencer: fault and startup sequencer of a quasi-resonant flyback
 * controller. Gates each turn-on but the first on secondary zero-current detection,
 * samples the line for brown-in, debounces all faults but over temperature, and runs the
 * auto-restart and latch-off cycles. Holds a small register port with
 * sticky events, a mask and one interrupt.
 * Assumes comparator flags arrive asynchronously, a 100 MHz clock and an
 * asynchronous reset that stands for supply collapse.
 */
// What this block does
// - turn on only after secondary zero current, first pulse excepted
// - flag off-time reaching 20 kHz floor period, no forced turn-on
// - sample line 100 us at supply turn-on
// - failed brown-in enters auto-restart, no switching
// - startup source off once switching starts
// - supply faults auto-restart, sense/temperature latch off
// - fault stops gate; low power below off
// - auto-restart clears protection, recharges at re-enable
// - auto-restart resumes at turn-on, repeats while faulty
// - latch-off recharges but never resumes switching
// - latch clears only at latch release level
// - supply over-voltage needs 70 us continuous assertion
// - brownout after line current low 16.5 ms
// - line current checked only while gate conducts
// - over temperature stops gate, latches off
// - sense over-voltage beyond two cycles latches off
// - zero current from comparator on plateau drop
`timescale 1ns/1ps

module ffs_sequencer #(
    parameter logic [ffs_pkg::CNT_W-1:0] SAMPLE_WINDOW_CYCLES =
        ffs_pkg::LINE_SAMPLE_WINDOW_CYC,
    parameter logic [ffs_pkg::CNT_W-1:0] SUPPLY_OV_CYCLES =
        ffs_pkg::SUPPLY_OV_DEBOUNCE_CYC,
    parameter logic [ffs_pkg::CNT_W-1:0] BROWNOUT_CYCLES =
        ffs_pkg::BROWNOUT_CYC,
    parameter logic [ffs_pkg::CNT_W-1:0] FLOOR_PERIOD_CYCLES =
        ffs_pkg::MIN_BOUNDARY_PERIOD_CYC,
    parameter logic [ffs_pkg::CYC_W-1:0] SENSE_OV_CYCLES =
        ffs_pkg::SENSE_OV_CYCLE_COUNT,
    parameter logic [ffs_pkg::CYC_W-1:0] SENSE_UV_CYCLES =
        ffs_pkg::SENSE_UV_CYCLE_COUNT
) (
    input wire logic clk_i,                          // core clock
    input wire logic rst_i,                          // supply collapse
    input wire ffs_pkg::ffs_cmp_t cmp_i,             // comparator flags
    input wire logic [ffs_pkg::ADDR_W-1:0] addr_i,   // register address
    input wire logic [ffs_pkg::DATA_W-1:0] wdata_i,  // write data
    input wire logic we_i,                           // write strobe
    input wire logic re_i,                           // read strobe
    output logic [ffs_pkg::DATA_W-1:0] rdata_o,      // read data
    output logic irq_o,                              // interrupt level
    output logic gate_o,                             // gate enable
    output logic hv_startup_en_o,                    // startup source on
    output logic sample_en_o,                        // line sampling on
    output logic low_power_o,                        // reduced current
    output logic latched_o                           // latch-off held
);
    import ffs_pkg::*;

    ffs_regs_t r;
    ffs_regs_t n;
    ffs_cmp_t s;
    logic [EV_W-1:0] ev;
    logic turn_off;
    logic fault_auto;
    logic fault_latch;
    logic status_rd;

    // synchronised comparator view, from the second flop only
    assign s = r.sync2;

    // status is cleared by a read of its own register
    assign status_rd = re_i && (addr_i == REG_EVENT_STATUS);

    // next-state logic of the whole sequencer
    always_comb begin
        n = r;
        ev = '0;
        turn_off = 1'b0;
        fault_auto = 1'b0;
        fault_latch = 1'b0;

        // two flops on every comparator flag
        n.sync1 = cmp_i;
        n.sync2 = r.sync1;

        case (r.st)
            // startup source charges the supply capacitor
            ST_CHARGE: begin
                if (s.supply_on) begin
                    n.tmr = '0;
                    if (r.latched) begin
                        n.st = ST_STOP;
                    end else begin
                        n.st = ST_SAMPLE;
                    end
                end
            end

            // line sampling window decides whether switching may start
            ST_SAMPLE: begin
                if (s.brown_in_ok) begin
                    n.st = ST_RUN;
                    n.zcd_seen = 1'b1;    // first pulse needs no detection
                    n.gate = 1'b0;
                    n.tmr = '0;
                    n.floor_hit = 1'b0;
                    n.ovp_cnt = '0;
                    n.bo_cnt = '0;
                    n.sov_cnt = '0;
                    n.suv_cnt = '0;
                end else if (r.tmr >= SAMPLE_WINDOW_CYCLES - 1'b1) begin
                    ev[EV_BROWN_IN_FAIL] = 1'b1;
                    n.st = ST_STOP;
                    n.latched = 1'b0;
                end else begin
                    n.tmr = r.tmr + 1'b1;
                end
            end

            // switching with zero-current gated turn-on
            ST_RUN: begin
                if (r.gate) begin
                    if (s.gate_off_req) begin
                        n.gate = 1'b0;
                        turn_off = 1'b1;
                        n.zcd_seen = 1'b0;
                        n.tmr = '0;
                        n.floor_hit = 1'b0;
                    end
                end else begin
                    if (s.zcd) begin
                        n.zcd_seen = 1'b1;
                    end
                    if (r.tmr != {CNT_W{1'b1}}) begin
                        n.tmr = r.tmr + 1'b1;
                    end
                    // note the off-time stretching to the frequency floor
                    if (r.tmr == FLOOR_PERIOD_CYCLES - 1'b1
                        && !r.floor_hit) begin
                        ev[EV_FREQ_FLOOR] = 1'b1;
                        n.floor_hit = 1'b1;
                    end
                    // oscillator done alone is not enough
                    if ((r.zcd_seen || s.zcd) && s.osc_done
                        && !r.soft_stop) begin
                        n.gate = 1'b1;
                    end
                end

                // supply over-voltage debounce, continuous assertion
                if (s.supply_ov) begin
                    if (r.ovp_cnt >= SUPPLY_OV_CYCLES - 1'b1) begin
                        fault_auto = 1'b1;
                        ev[EV_SUPPLY_OV] = 1'b1;
                    end else begin
                        n.ovp_cnt = r.ovp_cnt + 1'b1;
                    end
                end else begin
                    n.ovp_cnt = '0;
                end

                // brownout timer runs only during on-time
                if (r.gate) begin
                    if (s.line_low) begin
                        if (r.bo_cnt >= BROWNOUT_CYCLES) begin
                            fault_auto = 1'b1;
                            ev[EV_BROWNOUT] = 1'b1;
                        end else begin
                            n.bo_cnt = r.bo_cnt + 1'b1;
                        end
                    end else begin
                        n.bo_cnt = '0;
                    end
                end

                // junction temperature, no debounce
                if (s.over_temp) begin
                    fault_latch = 1'b1;
                    ev[EV_OVER_TEMP] = 1'b1;
                end

                // sense pin samples counted per switching cycle
                if (turn_off) begin
                    if (s.sense_ov) begin
                        if (r.sov_cnt >= SENSE_OV_CYCLES) begin
                            fault_latch = 1'b1;
                            ev[EV_SENSE_OV] = 1'b1;
                        end else begin
                            n.sov_cnt = r.sov_cnt + 1'b1;
                        end
                    end else begin
                        n.sov_cnt = '0;
                    end
                    if (s.sense_uv) begin
                        if (r.suv_cnt >= SENSE_UV_CYCLES) begin
                            fault_latch = 1'b1;
                            ev[EV_SENSE_UV] = 1'b1;
                        end else begin
                            n.suv_cnt = r.suv_cnt + 1'b1;
                        end
                    end else begin
                        n.suv_cnt = '0;
                    end
                end

                // any protection stops switching at once
                if (fault_auto || fault_latch) begin
                    n.gate = 1'b0;
                    n.st = ST_STOP;
                    n.latched = fault_latch;
                    n.ovp_cnt = '0;
                    n.bo_cnt = '0;
                    n.sov_cnt = '0;
                    n.suv_cnt = '0;
                end
            end

            // gate held off while the supply decays
            ST_STOP: begin
                n.gate = 1'b0;
                if (s.supply_off) begin
                    n.st = ST_LOWPWR;
                end
            end

            // reduced current until the startup re-enable level
            ST_LOWPWR: begin
                if (s.startup_reenable) begin
                    n.st = ST_CHARGE;
                end
            end

            default: begin
                n.st = ST_CHARGE;
                n.gate = 1'b0;
            end
        endcase

        // only a deep supply collapse frees a latch-off
        if (r.latched && s.latch_release) begin
            n.latched = 1'b0;
            n.st = ST_CHARGE;
            n.gate = 1'b0;
            ev[EV_LATCH_RELEASE] = 1'b1;
        end

        // register writes
        if (we_i) begin
            case (addr_i)
                REG_EVENT_MASK: n.mask = wdata_i[EV_W-1:0];
                REG_CONTROL: n.soft_stop = wdata_i[CTRL_SOFT_STOP];
                default: ;
            endcase
        end

        // sticky events, a new event wins over the read clear
        n.status = (r.status & ~{EV_W{status_rd}}) | ev;

        // read data stands only in the cycle after the strobe
        n.rdata = '0;
        if (re_i) begin
            case (addr_i)
                REG_EVENT_STATUS: n.rdata = DATA_W'(r.status);
                REG_EVENT_MASK: n.rdata = DATA_W'(r.mask);
                REG_SEQ_STATE: n.rdata = DATA_W'({r.zcd_seen, r.gate,
                                                  r.latched, r.st});
                REG_CONTROL: n.rdata = DATA_W'(r.soft_stop);
                default: n.rdata = '0;
            endcase
        end
    end

    // state register, constant values under reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.st <= ST_CHARGE;
        end else begin
            r <= n;
        end
    end

    // outputs decoded from the state register
    assign rdata_o = r.rdata;
    assign irq_o = |(r.status & r.mask);
    assign gate_o = r.gate;
    assign hv_startup_en_o = (r.st == ST_CHARGE)
        || (r.st == ST_SAMPLE);
    assign sample_en_o = (r.st == ST_SAMPLE);
    assign low_power_o = (r.st == ST_LOWPWR);
    assign latched_o = r.latched;

endmodule : ffs_sequencer

// [tb/ffs_seq_props.sv]
/* ffs_seq_props: port assertions of the sequencer, bound to its top.
   Assumes comparator flags act two to four edges after they change. */
`timescale 1ns/1ps
module ffs_seq_props #(
    parameter logic [ffs_pkg::CNT_W-1:0] SAMPLE_WINDOW_CYCLES =
        ffs_pkg::LINE_SAMPLE_WINDOW_CYC
) (
    input wire logic clk_i,              // core clock
    input wire logic rst_i,              // supply collapse
    input wire ffs_pkg::ffs_cmp_t cmp_i, // comparator flags
    input wire logic gate_o,             // gate enable
    input wire logic hv_startup_en_o,    // startup source
    input wire logic sample_en_o,        // line sampling
    input wire logic low_power_o,        // reduced current
    input wire logic latched_o           // latch-off held
);
    import ffs_pkg::*;
    ffs_cmp_t p1, p2, p3, p4, rc;
    logic [CNT_W-1:0] win;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // flag history and length of the current sampling window
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {p1, p2, p3, p4} <= '0;
            win <= '0;
        end else begin
            {p1, p2, p3, p4} <= {cmp_i, p1, p2, p3};
            win <= sample_en_o ? win + 1'b1 : '0;
        end
    end
    // a flag seen high at any of the last four edges
    assign rc = p1 | p2 | p3 | p4;
    a_gate_osc: assert property ($rose(gate_o) |-> rc.osc_done)
        else $error("gate rose before the oscillator period");
    a_hv_run: assert property (gate_o |-> !hv_startup_en_o)
        else $error("startup source on while switching");
    a_sample_hv: assert property (sample_en_o |->
        hv_startup_en_o && !gate_o)
        else $error("sampling without startup source or with gate");
    a_window_len: assert property (win <= SAMPLE_WINDOW_CYCLES + 2)
        else $error("sampling window too long");
    a_lowpwr_cause: assert property ($rose(low_power_o) |->
        rc.supply_off && !gate_o) else $error("low power without cause");
    a_recharge_cause: assert property ($rose(hv_startup_en_o) |->
        rc.startup_reenable || rc.latch_release)
        else $error("startup source on without cause");
    a_latch_hold: assert property ($fell(latched_o) |->
        rc.latch_release)
        else $error("latch cleared without release level");
    a_overtemp_stop: assert property (cmp_i.over_temp [*4] |=> !gate_o)
        else $error("gate on during over temperature");
endmodule : ffs_seq_props

bind ffs_sequencer ffs_seq_props #(
    .SAMPLE_WINDOW_CYCLES(SAMPLE_WINDOW_CYCLES)
) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .cmp_i(cmp_i), .gate_o(gate_o),
    .hv_startup_en_o(hv_startup_en_o), .sample_en_o(sample_en_o),
    .low_power_o(low_power_o), .latched_o(latched_o)
);

// [tb/ffs_stage_model.sv]
/* ffs_stage_model: power stage and secondary side: ends each on-time,
   flags zero current and the minimum off period.
   Assumes the gate enable is a registered level on the core clock. */
`timescale 1ns/1ps
module ffs_stage_model (
    input wire logic clk_i,      // core clock
    input wire logic gate_i,     // gate enable
    input wire logic zcd_hold_i, // keep secondary current from zero
    output logic zcd_o,          // zero current detected
    output logic osc_o,          // minimum off period elapsed
    output logic off_req_o       // peak current reached
);
    logic [7:0] cnt = 8'h00;
    logic last = 1'b0;
    // cycles since the last gate edge, saturating
    always_ff @(posedge clk_i) begin
        last <= gate_i;
        if (gate_i != last) cnt <= 8'h00;
        else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
    end
    // gating on last keeps a stale count from glitching a flag at an edge
    assign off_req_o = gate_i && last && cnt >= 8'h03;
    assign osc_o = !gate_i && !last && cnt >= 8'h02;
    assign zcd_o = !gate_i && !last && !zcd_hold_i && cnt >= 8'h04;
endmodule : ffs_stage_model

// [tb/ffs_sequencer_tb.sv]
/* ffs_sequencer_tb: self-checking bench of the sequencer, short counts.
   Assumes the stage model and the bound checker are compiled with it. */
`timescale 1ns/1ps
module ffs_sequencer_tb;
    import ffs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic hold = 1'b0;
    logic [ADDR_W-1:0] addr_i = 8'h00;
    logic [DATA_W-1:0] wdata_i = 32'h0;
    logic [DATA_W-1:0] rdata_o, d;
    logic irq_o, gate_o, hv_o, smp_o, lp_o, lat_o, zcd, osc, offq, gp;
    ffs_cmp_t c = '0;
    ffs_cmp_t cmp_i;
    int err_count = 0;
    int samples_checked = 0;
    int n;
    // switching-cycle flags come from the stage model
    always_comb begin
        cmp_i = c;
        cmp_i.zcd = zcd;
        cmp_i.osc_done = osc;
        cmp_i.gate_off_req = offq;
    end
    ffs_sequencer #(.SAMPLE_WINDOW_CYCLES(24'h14), .SUPPLY_OV_CYCLES(24'h0A),
        .BROWNOUT_CYCLES(24'h1E), .FLOOR_PERIOD_CYCLES(24'h0F)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .cmp_i(cmp_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .irq_o(irq_o), .gate_o(gate_o), .hv_startup_en_o(hv_o),
        .sample_en_o(smp_o), .low_power_o(lp_o), .latched_o(lat_o));
    ffs_stage_model stage (.clk_i(clk_i), .gate_i(gate_o),
        .zcd_hold_i(hold), .zcd_o(zcd), .osc_o(osc), .off_req_o(offq));
    // 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd
    task automatic ev(input int b);
        rd(REG_EVENT_STATUS);
        chk("status bit", 32'h1, 32'(d[b]));
    endtask : ev
    task automatic wait_st(input logic [4:0] s, input int lim);
        rd(REG_SEQ_STATE);
        for (int i = 1; i < lim && d[4:0] !== s; i++) rd(REG_SEQ_STATE);
        chk("state", 32'(s), 32'(d[4:0]));
    endtask : wait_st
    task automatic wait_gate(input logic v);
        for (int i = 0; i < 60 && gate_o !== v; i++) tick;
        chk("gate", 32'(v), 32'(gate_o));
    endtask : wait_gate
    task automatic count_on(input int cyc);
        n = 0;
        repeat (cyc) begin
            tick;
            n += gate_o;
        end
    endtask : count_on
    // supply falls to re-enable, recharges and reaches turn-on again
    task automatic descend;
        @(posedge clk_i);
        c.supply_on <= 1'b0;
        c.supply_off <= 1'b1;
        c.brown_in_ok <= 1'b1;
        repeat (5) tick;
        chk("low power", 1, lp_o);
        @(posedge clk_i);
        c.startup_reenable <= 1'b1;
        repeat (5) tick;
        chk("startup source", 1, hv_o);
        @(posedge clk_i);
        c.startup_reenable <= 1'b0;
        c.supply_off <= 1'b0;
        c.supply_on <= 1'b1;
    endtask : descend
    task automatic power_up;
        descend;
        wait_gate(1'b1);
        chk("startup source", 0, hv_o);
    endtask : power_up
    task automatic t_reset;
        chk("gate", 0, gate_o);
        chk("startup source", 1, hv_o);
        wait_st(ST_CHARGE, 1);
        wr(8'h40, 32'hFF);
        rd(8'h40);
        chk("unmapped", 0, d);
        $display("done reset");
    endtask : t_reset
    task automatic t_brown_in;
        wr(REG_EVENT_MASK, 32'h1);
        @(posedge clk_i);
        c.supply_on <= 1'b1;
        repeat (12) tick;
        wait_st(ST_SAMPLE, 1);
        chk("sampling", 1, smp_o);
        wait_st(ST_STOP, 10);
        chk("gate", 0, gate_o);
        chk("irq", 1, irq_o);
        ev(EV_BROWN_IN_FAIL);
        chk("irq", 0, irq_o);
        $display("done brown-in");
    endtask : t_brown_in
    // short glitch, then a hold just under and past the debounce
    task automatic t_supply_ov;
        power_up;
        @(posedge clk_i);
        c.supply_ov <= 1'b1;
        repeat (6) @(posedge clk_i);
        c.supply_ov <= 1'b0;
        repeat (4) @(posedge clk_i);
        c.supply_ov <= 1'b1;
        repeat (7) @(posedge clk_i);
        wait_st(ST_RUN, 1);
        wait_st(ST_STOP, 10);
        chk("latched", 0, lat_o);
        ev(EV_SUPPLY_OV);
        @(posedge clk_i);
        c.supply_ov <= 1'b0;
        power_up;
        $display("done supply over-voltage");
    endtask : t_supply_ov
    task automatic t_brownout;
        @(posedge clk_i);
        c.line_low <= 1'b1;
        repeat (40) tick;
        wait_st(ST_RUN, 1);
        wait_st(ST_STOP, 60);
        ev(EV_BROWNOUT);
        @(posedge clk_i);
        c.line_low <= 1'b0;
        $display("done brownout");
    endtask : t_brownout
    task automatic t_zcd;
        power_up;
        wait_gate(1'b0);
        @(posedge clk_i);
        hold <= 1'b1;
        count_on(40);
        chk("turn-ons while held", 0, n);
        ev(EV_FREQ_FLOOR);
        wr(REG_CONTROL, 32'h1);
        @(posedge clk_i);
        hold <= 1'b0;
        count_on(30);
        chk("turn-ons while stopped", 0, n);
        wr(REG_CONTROL, 32'h0);
        wait_gate(1'b1);
        $display("done zero current");
    endtask : t_zcd
    task automatic t_sense_ov;
        wait_gate(1'b0);
        @(posedge clk_i);
        c.sense_ov <= 1'b1;
        c.sense_uv <= 1'b1;
        n = 0;
        gp = 1'b0;
        for (int i = 0; i < 200 && lat_o !== 1'b1; i++) begin
            tick;
            if (gp && !gate_o) n++;
            gp = gate_o;
        end
        chk("turn-offs to latch", 3, n);
        chk("irq masked", 0, irq_o);
        ev(EV_SENSE_OV);
        chk("sense uv bit", 1, 32'(d[EV_SENSE_UV]));
        @(posedge clk_i);
        c.sense_ov <= 1'b0;
        c.sense_uv <= 1'b0;
        descend;
        chk("latched", 1, lat_o);
        count_on(30);
        chk("turn-ons when latched", 0, n);
        rd(REG_SEQ_STATE);
        chk("state", 32'h28, 32'(d[5:0]));
        @(posedge clk_i);
        c.latch_release <= 1'b1;
        repeat (5) tick;
        chk("latched", 0, lat_o);
        ev(EV_LATCH_RELEASE);
        @(posedge clk_i);
        c.latch_release <= 1'b0;
        $display("done latch-off");
    endtask : t_sense_ov
    task automatic t_over_temp;
        wait_gate(1'b1);
        @(posedge clk_i);
        c.over_temp <= 1'b1;
        repeat (5) tick;
        chk("latched", 1, lat_o);
        chk("gate", 0, gate_o);
        ev(EV_OVER_TEMP);
        @(posedge clk_i);
        c.over_temp <= 1'b0;
        $display("done over temperature");
    endtask : t_over_temp
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    // main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        tick;
        t_reset;
        t_brown_in;
        t_supply_ov;
        t_brownout;
        t_zcd;
        t_sense_ov;
        t_over_temp;
        stop_test;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        err_count++;
        stop_test;
    end
endmodule : ffs_sequencer_tb
